// *** logic/clock_unit_pkg.sv ***
// Package with register map, reset values and encodings of the clock unit
`default_nettype none
package clock_unit_pkg;
	// Register indices, byte address is four times the index
	localparam logic [7:0] IDX_GATE0 = 8'h63;
	localparam logic [7:0] IDX_GATE1 = 8'h64;
	localparam logic [7:0] IDX_GATE2 = 8'h65;
	localparam logic [7:0] IDX_SYSSEL = 8'h66;
	localparam logic [7:0] IDX_I2SSTEP = 8'h67;
	localparam logic [7:0] IDX_I2SMOD = 8'h68;
	localparam logic [7:0] IDX_CODECSTEP = 8'h6C;
	localparam logic [7:0] IDX_CODECMOD = 8'h6D;
	localparam logic [7:0] IDX_ROOTHI = 8'h70;
	localparam logic [7:0] IDX_STATUS = 8'h71;
	// Reset values
	localparam logic [7:0] RST_GATE0 = 8'h83;
	localparam logic [7:0] RST_GATE1 = 8'h00;
	localparam logic [7:0] RST_GATE2 = 8'h30;
	localparam logic [7:0] RST_SYSSEL = 8'h06;
	localparam logic [7:0] RST_I2SSTEP = 8'h00;
	localparam logic [7:0] RST_I2SMOD = 8'h02;
	localparam logic [7:0] RST_CODECSTEP = 8'h01;
	localparam logic [7:0] RST_CODECMOD = 8'h02;
	localparam logic [7:0] RST_ROOTHI = 8'h00;
	// Field positions
	localparam int SEL_ROOT_BIT = 7;
	localparam int SEL_SRC_HI = 6;
	localparam int SEL_SRC_LO = 5;
	localparam int SEL_DIV_HI = 4;
	localparam int STEP_EN_BIT = 7;
	localparam int USB_GATE_BIT = 3;
	// Two-of-three divider last count of its three-tick cycle
	localparam logic [1:0] TWO_THIRDS_LAST = 2'd2;
	// System clock source encoding
	typedef enum logic [1:0]
	{
		SRC_RC = 2'b00,
		SRC_ROOT = 2'b01,
		SRC_DIV = 2'b10,
		SRC_32M = 2'b11
	} sys_src_e;
endpackage
`default_nettype wire

// *** logic/system_and_module_clock_unit.sv ***
// System and module clock unit: source muxes, dividers, gates and APB registers
//
// Contract
// - Internal 24 MHz RC clock is a selectable system clock source.
// - Crystal 24 MHz is doubled into 48 MHz feeding CODEC, I2S and USB.
// - Bits 6..5 of the select register pick one of four sources.
// - Source codes: 00 RC, 01 root, 10 divided root, 11 32 MHz.
// - Code 10 gives root clock divided by bits 4..0.
// - 32 MHz source is two thirds of the 48 MHz clock.
// - Root clock picked by root-high bit 0 and select bit 7.
// - Root codes: 00 doubled 48 MHz, 01 RC, 1x crystal pad clock.
// - Three consecutive gate registers hold per-module clock enables.
// - Gate bit one runs module clock, zero stops it.
// - Timer clock is two thirds of the crystal clock, 16 MHz.
// - USB clock comes from the doubled 48 MHz clock.
// - I2S clock runs only while its step register bit 7 is set.
// - I2S clock equals 48 MHz times step over mod.
// - CODEC clock runs only while its step register bit 7 is set.
// - CODEC clock equals 48 MHz times step over mod.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module system_and_module_clock_unit
	import clock_unit_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rcTick,
	input wire logic xtalTick,
	output logic dblTick,
	output logic sysTick,
	output logic timerTick,
	output logic usbClkEn,
	output logic [23:0] moduleClkEn,
	output logic i2sClk,
	output logic codecClk
);
	// Oscillators arrive as one-cycle enables; every clock here except the level outputs i2sClk and codecClk is such an enable
	logic [7:0] gate0_q, gate1_q, gate2_q, sysSel_q, i2sStep_q, i2sMod_q;
	logic [7:0] codecStep_q, codecMod_q, rootHi_q;
	logic [7:0] rdVal;
	logic [9:0] idx;
	logic hit, setup, access;
	logic [1:0] pend_q, pend_d;
	logic [1:0] dblCnt_q, xtalCnt_q;
	logic tick32, rootTick;
	logic [1:0] rootSel;
	logic [4:0] divCnt_q;
	logic divTick;
	logic [1:0] srcAct_q;
	logic switching;
	logic sysTickRaw;
	logic [7:0] statusVal;

	assign idx = paddr[11:2];
	assign setup = psel && !penable;
	assign access = psel && penable;

	always_comb
	begin
		hit = 1'b1;
		rdVal = 8'h00;
		unique case (idx[7:0])
			IDX_GATE0: rdVal = gate0_q;
			IDX_GATE1: rdVal = gate1_q;
			IDX_GATE2: rdVal = gate2_q;
			IDX_SYSSEL: rdVal = sysSel_q;
			IDX_I2SSTEP: rdVal = i2sStep_q;
			IDX_I2SMOD: rdVal = i2sMod_q;
			IDX_CODECSTEP: rdVal = codecStep_q;
			IDX_CODECMOD: rdVal = codecMod_q;
			IDX_ROOTHI: rdVal = rootHi_q;
			IDX_STATUS: rdVal = statusVal;
			default: hit = 1'b0;
		endcase
		if (idx[9:8] != 2'b00)
			hit = 1'b0;
	end

	// Zero-wait slave; read data is captured in the setup cycle
	assign pready = access;
	assign pslverr = access && (!hit || (pwrite && idx[7:0] == IDX_STATUS));

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prdata <= 32'h0000_0000;
		else if (setup && !pwrite)
			prdata <= {24'h00_0000, rdVal};
	end

	logic wr;
	assign wr = access && pwrite;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			gate0_q <= RST_GATE0;
			gate1_q <= RST_GATE1;
			gate2_q <= RST_GATE2;
			sysSel_q <= RST_SYSSEL;
			i2sStep_q <= RST_I2SSTEP;
			i2sMod_q <= RST_I2SMOD;
			codecStep_q <= RST_CODECSTEP;
			codecMod_q <= RST_CODECMOD;
			rootHi_q <= RST_ROOTHI;
		end
		else if (wr && idx[9:8] == 2'b00)
		begin
			unique case (idx[7:0])
				IDX_GATE0: gate0_q <= pwdata[7:0];
				IDX_GATE1: gate1_q <= pwdata[7:0];
				IDX_GATE2: gate2_q <= pwdata[7:0];
				IDX_SYSSEL: sysSel_q <= pwdata[7:0];
				IDX_I2SSTEP: i2sStep_q <= pwdata[7:0];
				IDX_I2SMOD: i2sMod_q <= pwdata[7:0];
				IDX_CODECSTEP: codecStep_q <= pwdata[7:0];
				IDX_CODECMOD: codecMod_q <= pwdata[7:0];
				IDX_ROOTHI: rootHi_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Doubler: each crystal tick yields two ticks; backlog capped at three
	always_comb
	begin
		pend_d = pend_q - {1'b0, pend_q != 2'd0};
		if (xtalTick)
			pend_d = (pend_d == 2'd0) ? 2'd2 : 2'd3;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pend_q <= 2'd0;
		else
			pend_q <= pend_d;
	end
	assign dblTick = pend_q != 2'd0;

	// Two-of-three dividers drop every third input tick
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			dblCnt_q <= 2'd0;
		else if (dblTick)
			dblCnt_q <= (dblCnt_q == TWO_THIRDS_LAST) ? 2'd0 : dblCnt_q + 2'd1;
	end
	assign tick32 = dblTick && dblCnt_q != TWO_THIRDS_LAST;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			xtalCnt_q <= 2'd0;
		else if (xtalTick)
			xtalCnt_q <= (xtalCnt_q == TWO_THIRDS_LAST) ? 2'd0 : xtalCnt_q + 2'd1;
	end
	assign timerTick = xtalTick && xtalCnt_q != TWO_THIRDS_LAST;

	// Root clock
	assign rootSel = {rootHi_q[0], sysSel_q[SEL_ROOT_BIT]};
	always_comb
	begin
		unique case (rootSel)
			2'b00: rootTick = dblTick;
			2'b01: rootTick = rcTick;
			default: rootTick = xtalTick;
		endcase
	end

	// Root divider; values 0 and 1 are not supported and act as divide-by-one
	// A select write restarts the count, so a smaller divider never sees a stale count
	logic selWr;
	assign selWr = wr && idx == {2'b00, IDX_SYSSEL};
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			divCnt_q <= 5'd0;
		else if (selWr)
			divCnt_q <= 5'd0;
		else if (rootTick)
			divCnt_q <= (divCnt_q + 5'd1 >= sysSel_q[SEL_DIV_HI:0]) ? 5'd0 : divCnt_q + 5'd1;
	end
	assign divTick = rootTick && (divCnt_q + 5'd1 >= sysSel_q[SEL_DIV_HI:0]);

	// Source switch takes effect after one idle cycle so no pulse is split
	assign switching = srcAct_q != sysSel_q[SEL_SRC_HI:SEL_SRC_LO];
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			srcAct_q <= RST_SYSSEL[SEL_SRC_HI:SEL_SRC_LO];
		else
			srcAct_q <= sysSel_q[SEL_SRC_HI:SEL_SRC_LO];
	end

	always_comb
	begin
		unique case (sys_src_e'(srcAct_q))
			SRC_RC: sysTickRaw = rcTick;
			SRC_ROOT: sysTickRaw = rootTick;
			SRC_DIV: sysTickRaw = divTick;
			SRC_32M: sysTickRaw = tick32;
		endcase
	end
	assign sysTick = sysTickRaw && !switching;

	// Module gates act on whole ticks, so a gated clock is simply absent
	assign moduleClkEn = {gate2_q, gate1_q, gate0_q} & {24{sysTick}};
	assign usbClkEn = dblTick && gate0_q[USB_GATE_BIT];

	// Step/mod phase accumulators, one per audio clock
	logic [7:0] stepReg [2];
	logic [7:0] modReg [2];
	logic [1:0] fracClk;
	assign stepReg[0] = i2sStep_q;
	assign stepReg[1] = codecStep_q;
	assign modReg[0] = i2sMod_q;
	assign modReg[1] = codecMod_q;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_frac
			logic [8:0] acc_q;
			logic [8:0] sum;
			logic en;
			logic clk_q;
			assign en = stepReg[ch][STEP_EN_BIT];
			assign sum = acc_q + {2'b00, stepReg[ch][6:0]};
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
					acc_q <= 9'd0;
				else if (!en)
					acc_q <= 9'd0;
				else if (dblTick)
					acc_q <= (sum >= {1'b0, modReg[ch]}) ? sum - {1'b0, modReg[ch]} : sum;
			end
			// High for the upper half of each wrap period: rate is 48 MHz*step/mod
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
					clk_q <= 1'b0;
				else
					clk_q <= en && (acc_q >= {2'b00, modReg[ch][7:1]});
			end
			assign fracClk[ch] = clk_q;
		end
	endgenerate
	assign i2sClk = fracClk[0];
	assign codecClk = fracClk[1];

	assign statusVal = {2'b00, switching, dblTick, rootSel, srcAct_q};

	// Checks
	stop_i2s_a: assert property (@(posedge clk) disable iff (rst)
		!i2sStep_q[STEP_EN_BIT] |=> !i2sClk)
		else $error("i2s clock high while disabled");
	stop_codec_a: assert property (@(posedge clk) disable iff (rst)
		!codecStep_q[STEP_EN_BIT] |=> !codecClk)
		else $error("codec clock high while disabled");
	doubler_two_a: assert property (@(posedge clk) disable iff (rst)
		xtalTick && pend_q == 2'd0 |=> dblTick ##1 dblTick)
		else $error("doubler gave fewer than two ticks");
	thirty_two_a: assert property (@(posedge clk) disable iff (rst)
		dblTick && dblCnt_q == TWO_THIRDS_LAST |-> !tick32)
		else $error("two thirds divider passed third tick");
	timer_third_a: assert property (@(posedge clk) disable iff (rst)
		xtalTick && xtalCnt_q != TWO_THIRDS_LAST |-> timerTick)
		else $error("timer tick missing");
	div_count_a: assert property (@(posedge clk) disable iff (rst)
		divTick && sysSel_q[SEL_DIV_HI:0] > 5'd1 |-> divCnt_q == sysSel_q[SEL_DIV_HI:0] - 5'd1)
		else $error("divider tick at wrong count");
	gate_off_a: assert property (@(posedge clk) disable iff (rst)
		!gate0_q[0] |-> !moduleClkEn[0])
		else $error("gated module clock running");
	usb_src_a: assert property (@(posedge clk) disable iff (rst)
		gate0_q[USB_GATE_BIT] |-> usbClkEn == dblTick)
		else $error("usb clock not from doubled clock");
	switch_idle_a: assert property (@(posedge clk) disable iff (rst)
		$changed(sysSel_q[SEL_SRC_HI:SEL_SRC_LO]) |-> !sysTick)
		else $error("tick during source switch");
	read_sel_a: assert property (@(posedge clk) disable iff (rst)
		setup && !pwrite && idx == {2'b00, IDX_SYSSEL} |=> prdata[7:0] == $past(sysSel_q))
		else $error("select register read mismatch");

	rc_source_a: assert property (@(posedge clk) disable iff (rst)
		srcAct_q == SRC_RC && !switching |-> sysTick == rcTick)
		else $error("rc source not passed to system clock");
	root_source_a: assert property (@(posedge clk) disable iff (rst)
		srcAct_q == SRC_ROOT && !switching |-> sysTick == rootTick)
		else $error("root source not passed to system clock");
	div_source_a: assert property (@(posedge clk) disable iff (rst)
		srcAct_q == SRC_DIV && !switching |-> sysTick == divTick)
		else $error("divided source not passed to system clock");
	src_32m_a: assert property (@(posedge clk) disable iff (rst)
		srcAct_q == SRC_32M && !switching |-> sysTick == tick32)
		else $error("two thirds source not passed to system clock");
	root_pick_a: assert property (@(posedge clk) disable iff (rst)
		(rootSel == 2'b00 && rootTick == dblTick) || (rootSel == 2'b01 && rootTick == rcTick)
		|| (rootSel[1] && rootTick == xtalTick))
		else $error("root clock from wrong source");
	gate_write_a: assert property (@(posedge clk) disable iff (rst)
		wr && idx == {2'b00, IDX_GATE1} |=> gate1_q == $past(pwdata[7:0]))
		else $error("gate register write lost");
	gate_run_a: assert property (@(posedge clk) disable iff (rst)
		sysTick |-> moduleClkEn == {gate2_q, gate1_q, gate0_q})
		else $error("enabled module clock missing");
	usb_gate_a: assert property (@(posedge clk) disable iff (rst)
		!gate0_q[USB_GATE_BIT] |-> !usbClkEn)
		else $error("gated usb clock running");
	timer_xtal_a: assert property (@(posedge clk) disable iff (rst)
		timerTick |-> xtalTick)
		else $error("timer tick without crystal tick");
	dbl_quiet_a: assert property (@(posedge clk) disable iff (rst)
		pend_q == 2'd0 && !xtalTick |=> !dblTick)
		else $error("doubler tick without crystal tick");
	gate_idle_a: assert property (@(posedge clk) disable iff (rst)
		switching |-> moduleClkEn == 24'h000000)
		else $error("module clock during source switch");

	div_used_c: cover property (@(posedge clk) disable iff (rst)
		srcAct_q == SRC_DIV && sysTick);
	i2s_run_c: cover property (@(posedge clk) disable iff (rst)
		$rose(i2sClk));
	codec_run_c: cover property (@(posedge clk) disable iff (rst)
		$rose(codecClk));
	switch_c: cover property (@(posedge clk) disable iff (rst)
		switching);
	usb_run_c: cover property (@(posedge clk) disable iff (rst)
		usbClkEn);
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the system and module clock unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import clock_unit_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic rcTick = 1'b0;
	logic xtalTick = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, dblTick, sysTick, timerTick, usbClkEn, i2sClk, codecClk;
	logic [23:0] moduleClkEn;
	logic [23:0] gates = {RST_GATE2, RST_GATE1, RST_GATE0};
	logic lastI = 1'b0;
	logic lastC = 1'b0;
	logic [7:0] obs;
	logic [9:0] e;
	logic [9:0] q[$];
	logic [7:0] rIdx [9] = '{IDX_GATE0, IDX_GATE1, IDX_GATE2, IDX_SYSSEL, IDX_I2SSTEP,
		IDX_I2SMOD, IDX_CODECSTEP, IDX_CODECMOD, IDX_ROOTHI};
	logic [7:0] rVal [9] = '{RST_GATE0, RST_GATE1, RST_GATE2, RST_SYSSEL, RST_I2SSTEP,
		RST_I2SMOD, RST_CODECSTEP, RST_CODECMOD, RST_ROOTHI};
	logic [7:0] sSel [8] = '{8'h06, 8'h20, 8'hA0, 8'h20, 8'hA0, 8'h44, 8'h43, 8'h60};
	logic sRoot [8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	int err_count = 0;
	int cmp_count = 0;
	int seed = 32'h9748;
	int ph = 0;
	int mis, base, ex;
	int c [8];
	logic [7:0] g;

	always #12.5 clk = ~clk;

	system_and_module_clock_unit dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rcTick(rcTick), .xtalTick(xtalTick), .dblTick(dblTick),
		.sysTick(sysTick), .timerTick(timerTick), .usbClkEn(usbClkEn),
		.moduleClkEn(moduleClkEn), .i2sClk(i2sClk), .codecClk(codecClk));

	// Crystal ticks every third cycle keep the doubler's two-cycle spacing
	always @(posedge clk)
	begin
		ph <= (ph == 2) ? 0 : ph + 1;
		xtalTick <= (ph == 2);
		rcTick <= ($random(seed) % 3) == 0;
		lastI <= i2sClk;
		lastC <= codecClk;
	end
	assign obs = {codecClk & ~lastC, i2sClk & ~lastI, usbClkEn, timerTick, sysTick, dblTick,
		xtalTick, rcTick};

	task automatic chk(input string nm, input logic [31:0] exv, input logic [31:0] got);
		cmp_count++;
		if (got !== exv)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exv, got);
		end
	endtask

	// Rates are compared with a small band for divider phase at the window edges
	task automatic rng(input string nm, input int v, input int exv);
		cmp_count++;
		if (v < exv - 2 || v > exv + 2)
		begin
			err_count++;
			$display("[ERR] %s expected %0d seen %0d", nm, exv, v);
		end
	endtask

	task automatic conclude();
		$display("Compares %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
		input logic er);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, d};
		q.push_back({wr, er, d});
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (k == 20)
		begin
			chk("pready", 32'h1, 32'h0);
			conclude();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	always @(posedge clk)
		if (psel && penable && pready === 1'b1)
		begin
			e = q.pop_front();
			chk("pslverr", {31'h0, e[8]}, {31'h0, pslverr});
			if (!e[9] && !e[8])
				chk("prdata", {24'h000000, e[7:0]}, prdata);
		end

	task automatic measure(input int n);
		foreach (c[i])
			c[i] = 0;
		mis = 0;
		repeat (n)
		begin
			@(posedge clk);
			foreach (c[i])
				c[i] += obs[i];
			mis += (moduleClkEn !== (gates & {24{sysTick}}));
			mis += $isunknown(obs);
		end
	endtask

	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 9; i++)
			apb(1'b0, rIdx[i], rVal[i], 1'b0);
		apb(1'b0, 8'h69, 8'h00, 1'b1);
		apb(1'b1, IDX_STATUS, 8'h00, 1'b1);
		measure(300);
		chk("i2sOff", 32'h0, c[6]);
		chk("codecOff", 32'h0, c[7]);
		chk("usbGated", 32'h0, c[5]);
		chk("gateMis", 32'h0, mis);
		chk("rcSys", c[0], c[3]);
		rng("dbl", c[2], 2 * c[1]);
		rng("timer", c[4], c[1] * 2 / 3);
		$display("Reset and map test done");
		for (int t = 0; t < 3; t++)
		begin
			g = 8'($random(seed)) | ((t == 0) ? 8'h08 : 8'h00);
			apb(1'b1, 8'(IDX_GATE0 + t), g, 1'b0);
			gates[8 * t +: 8] = g;
			apb(1'b0, 8'(IDX_GATE0 + t), g, 1'b0);
		end
		measure(300);
		chk("gateMis", 32'h0, mis);
		chk("usb", c[2], c[5]);
		$display("Gate test done");
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, IDX_ROOTHI, {7'h00, sRoot[i]}, 1'b0);
			apb(1'b1, IDX_SYSSEL, sSel[i], 1'b0);
			apb(1'b0, IDX_SYSSEL, sSel[i], 1'b0);
			measure(300);
			base = ({sRoot[i], sSel[i][7]} == 2'b00) ? c[2] : (!sRoot[i] ? c[0] : c[1]);
			case (sSel[i][6:5])
				2'b00: ex = c[0];
				2'b01: ex = base;
				2'b10: ex = base / sSel[i][4:0];
				default: ex = c[2] * 2 / 3;
			endcase
			rng("sysTick", c[3], ex);
			chk("gateMis", 32'h0, mis);
		end
		$display("Source test done");
		apb(1'b1, IDX_I2SMOD, 8'h04, 1'b0);
		apb(1'b1, IDX_I2SSTEP, 8'h81, 1'b0);
		apb(1'b1, IDX_CODECMOD, 8'h08, 1'b0);
		apb(1'b1, IDX_CODECSTEP, 8'h83, 1'b0);
		measure(600);
		chk("gateMis", 32'h0, mis);
		rng("i2sRise", c[6], c[2] / 4);
		rng("codecRise", c[7], c[2] * 3 / 8);
		apb(1'b1, IDX_I2SSTEP, 8'h01, 1'b0);
		apb(1'b1, IDX_CODECSTEP, 8'h03, 1'b0);
		measure(100);
		chk("i2sStop", 32'h0, c[6] + i2sClk);
		chk("codecStop", 32'h0, c[7] + codecClk);
		$display("Audio clock test done");
		conclude();
	end
endmodule
`default_nettype wire
